// File: crf_pkg.sv
// constants, types and helpers shared by the receive filter and sleep block
// Behaviour
// - invalid background frame is overwritten, never queued
// - own frames neither captured nor queued, no ack
// - loopback treats own frames as received ones
// - lost arbitration turns transmitter into receiver
// - full queue: drop new frame, flag overrun
// - keep transmitting while full, resume when free
// - masked identifier bits are don't care
// - acceptance sets full flag and hit index
// - lowest matching filter section wins
// - four filter modes from acceptance control
// - wide filter covers id, rtr, ide, srr
// - bytes 0-3 filter 0, 4-7 filter 1
// - wake on bus activity or request clear
// - early request clear has no effect until sleep is reached, then it wakes
// - eleven recessive bits before resynchronising
// - keep buffers, run pending actions on wake
// - bus-off recovery count survives sleep
package crf_pkg;

  // ----------------------------------------------------------------
  // acceptance filter modes
  // ----------------------------------------------------------------
  localparam logic [1:0] ACC_TWO32  = 2'h0;
  localparam logic [1:0] ACC_FOUR16 = 2'h1;
  localparam logic [1:0] ACC_EIGHT8 = 2'h2;
  localparam logic [1:0] ACC_CLOSED = 2'h3;

  // ----------------------------------------------------------------
  // sleep states, gray along sync-awake-pending-asleep
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SL_SYNC   = 2'h0,
    SL_AWAKE  = 2'h1,
    SL_PEND   = 2'h3,
    SL_ASLEEP = 2'h2
  } crf_sleep_e;

  // ----------------------------------------------------------------
  // bus timing counts
  // ----------------------------------------------------------------
  localparam int         REC_RUN_BITS  = 11;
  localparam logic [3:0] REC_RUN_LAST  = 4'(REC_RUN_BITS - 1);
  localparam int         BUSOFF_RUNS   = 128;
  localparam logic [6:0] BUSOFF_LAST   = 7'(BUSOFF_RUNS - 1);

  // ----------------------------------------------------------------
  // stored frame word layout
  // ----------------------------------------------------------------
  localparam int ID_W       = 29;
  localparam int STD_ID_W   = 11;
  localparam int F_ID_LSB   = 0;
  localparam int F_IDE      = 29;
  localparam int F_RTR      = 30;
  localparam int F_DATA_LSB = 31;
  localparam int F_DLC_LSB  = 95;
  localparam int F_HIT_LSB  = 99;
  localparam int RXW        = 102;

  function automatic logic crf_bmatch(input logic [7:0] p,
                                      input logic [7:0] m,
                                      input logic [7:0] h);
    return &(~(p ^ h) | m);
  endfunction

endpackage

// File: crf_rx_buf2.sv
// two-entry receive queue with valid and ready on both sides
`timescale 1ns/1ps
module crf_rx_buf2 import crf_pkg::*; #(
  parameter int W = RXW
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              wp;
    logic              rp;
    logic [1:0]        cnt;
  } crf_buf_s;

  crf_buf_s st;
  crf_buf_s next_st;
  logic     wr;
  logic     rd;

  assign in_ready  = (st.cnt != 2'h2);
  assign out_valid = (st.cnt != 2'h0);
  assign out_data  = st.mem[st.rp];

  always_comb begin
    next_st = st;
    wr      = in_valid & in_ready;
    rd      = out_valid & out_ready;
    if (wr) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp         = ~st.wp;
    end
    if (rd) begin
      next_st.rp = ~st.rp;
    end
    next_st.cnt = st.cnt + {1'b0, wr} - {1'b0, rd};
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// File: crf_rx_filter_sleep.sv
// receive buffering, acceptance filter and sleep control of the CAN node
`timescale 1ns/1ps
module crf_rx_filter_sleep import crf_pkg::*; (
  input  wire logic            mclk,
  input  wire logic            rst,
  // bus pin and bit framing from the protocol engine
  input  wire logic            can_rx,
  input  wire logic            bit_tick,
  input  wire logic            tx_start,
  input  wire logic            arb_lost,
  input  wire logic            frame_done,
  input  wire logic            frame_error,
  input  wire logic [ID_W-1:0] rx_id,
  input  wire logic            rx_ide,
  input  wire logic            rx_rtr,
  input  wire logic            rx_srr,
  input  wire logic [3:0]      rx_dlc,
  input  wire logic [63:0]     rx_data,
  input  wire logic            bus_idle,
  input  wire logic            bus_off,
  // control bits
  input  wire logic            loopback,
  input  wire logic [1:0]      acceptance_control_reg,
  input  wire logic [7:0][7:0] id_accept_pattern_regs,
  input  wire logic [7:0][7:0] id_mask_regs,
  input  wire logic            overrun_ie,
  input  wire logic            wakeup_enable,
  input  wire logic            sleep_request,
  input  wire logic            fg_release,
  // foreground buffer and status
  output logic                 rx_buffer_full_flag,
  output logic [2:0]           filter_hit_index,
  output logic [ID_W-1:0]      fg_id,
  output logic                 fg_ide,
  output logic                 fg_rtr,
  output logic [3:0]           fg_dlc,
  output logic [63:0]          fg_data,
  output logic                 rx_irq,
  output logic                 overrun,
  output logic                 err_irq,
  output logic                 can_ack_enable,
  output logic                 tx_hold,
  output logic                 sleep_acknowledge,
  output logic                 wakeup_pulse,
  output logic                 bus_off_recovered,
  output logic                 bus_synced
);

  // ----------------------------------------------------------------
  // filter helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] crf_header(input logic            ide,
                                             input logic            srr,
                                             input logic            rtr,
                                             input logic [ID_W-1:0] id);
    logic [31:0] h;
    if (ide) begin
      h = {id[28:21], id[20:18], srr, ide, id[17:15], id[14:7], id[6:0], rtr};
    end else begin
      h = {id[10:3], id[2:0], rtr, ide, 3'h0, 16'h0};
    end
    return h;
  endfunction

  // result is {hit, index}; filter k uses pattern bytes k*n .. k*n+n-1
  function automatic logic [3:0] crf_filter(input logic [1:0]      mode,
                                            input logic [7:0][7:0] pat,
                                            input logic [7:0][7:0] msk,
                                            input logic [31:0]     hdr);
    logic [3:0] res;
    logic       ok;
    int         n;
    res = 4'h0;
    ok  = 1'b0;
    n   = 0;
    unique case (mode)
      ACC_TWO32:  n = 4;
      ACC_FOUR16: n = 2;
      ACC_EIGHT8: n = 1;
      ACC_CLOSED: n = 0;
    endcase
    if (n != 0) begin
      // walk downward so the lowest matching section is left standing
      for (int k = 7; k >= 0; k--) begin
        if (k < 8 / n) begin
          ok = 1'b1;
          for (int j = 0; j < 4; j++) begin
            if (j < n) begin
              if (!crf_bmatch(pat[k * n + j], msk[k * n + j], hdr[31 - 8 * j -: 8])) begin
                ok = 1'b0;
              end
            end
          end
          if (ok) begin
            res = {1'b1, 3'(k)};
          end
        end
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]     rx_sync;
    logic           rx_prev;
    logic           req_prev;
    crf_sleep_e     sleep;
    logic           own_tx;
    logic           bg_valid;
    logic [RXW-1:0] bg;
    logic [3:0]     rec_run;
    logic [6:0]     busoff_runs;
    logic           rx_irq;
    logic           ovr;
    logic           err_irq;
    logic           wake;
    logic           recovered;
  } crf_st_s;

  crf_st_s        st;
  crf_st_s        next_st;
  logic [31:0]    hdr;
  logic [3:0]     flt;
  logic           dom_edge;
  logic           run_evt;
  logic           rx_en;
  logic           push;
  logic           bg_free;
  logic           accept;
  logic           q_in_valid;
  logic           q_in_ready;
  logic           q_out_valid;
  logic [RXW-1:0] q_out_data;

  // ----------------------------------------------------------------
  // receive queue
  // ----------------------------------------------------------------
  // pending copies wait while asleep, then run on wake
  assign q_in_valid = st.bg_valid & (st.sleep != SL_ASLEEP);

  crf_rx_buf2 #(
    .W (RXW)
  ) u_queue (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (q_in_valid),
    .in_ready  (q_in_ready),
    .in_data   (st.bg),
    .out_valid (q_out_valid),
    .out_ready (fg_release),
    .out_data  (q_out_data)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st  = st;
    hdr      = crf_header(rx_ide, rx_srr, rx_rtr, rx_id);
    flt      = crf_filter(acceptance_control_reg, id_accept_pattern_regs, id_mask_regs, hdr);
    dom_edge = st.rx_prev & ~st.rx_sync[1];
    run_evt  = 1'b0;
    rx_en    = (st.sleep == SL_AWAKE) || (st.sleep == SL_PEND);
    push     = q_in_valid & q_in_ready;
    bg_free  = ~st.bg_valid | push;
    accept   = frame_done & rx_en & ~frame_error & flt[3] & (~st.own_tx | loopback);

    next_st.rx_sync   = {st.rx_sync[0], can_rx};
    next_st.rx_prev   = st.rx_sync[1];
    next_st.req_prev  = sleep_request;
    next_st.rx_irq    = 1'b0;
    next_st.ovr       = 1'b0;
    next_st.err_irq   = 1'b0;
    next_st.wake      = 1'b0;
    next_st.recovered = 1'b0;

    // recessive run detector, held at zero while asleep
    if (st.sleep == SL_ASLEEP) begin
      next_st.rec_run = 4'h0;
    end else if (bit_tick) begin
      if (!st.rx_sync[1]) begin
        next_st.rec_run = 4'h0;
      end else if (st.rec_run == REC_RUN_LAST) begin
        next_st.rec_run = 4'h0;
        run_evt         = 1'b1;
      end else begin
        next_st.rec_run = st.rec_run + 4'h1;
      end
    end

    // bus-off recovery; sleep does not clear the count
    if (!bus_off) begin
      next_st.busoff_runs = 7'h00;
    end else if (run_evt) begin
      if (st.busoff_runs == BUSOFF_LAST) begin
        next_st.busoff_runs = 7'h00;
        next_st.recovered   = 1'b1;
      end else begin
        next_st.busoff_runs = st.busoff_runs + 7'h01;
      end
    end

    // own transmission tracking
    if (tx_start) begin
      next_st.own_tx = 1'b1;
    end
    if (arb_lost || frame_done) begin
      next_st.own_tx = 1'b0;
    end

    // background buffer to queue
    if (push) begin
      next_st.bg_valid = 1'b0;
      next_st.rx_irq   = 1'b1;
    end

    // rejected or broken frames never load, so the slot is simply reused
    if (accept) begin
      if (bg_free) begin
        next_st.bg_valid = 1'b1;
        next_st.bg       = {flt[2:0], rx_dlc, rx_data, rx_rtr, rx_ide, rx_id};
      end else begin
        next_st.ovr     = 1'b1;
        next_st.err_irq = overrun_ie;
      end
    end

    // sleep control
    unique case (st.sleep)
      SL_SYNC: begin
        if (run_evt) begin
          next_st.sleep = SL_AWAKE;
        end
      end
      SL_AWAKE: begin
        if (sleep_request && !st.req_prev) begin
          next_st.sleep = SL_PEND;
        end
      end
      SL_PEND: begin
        // a request dropped here is ignored until sleep is reached
        if (bus_idle && !st.own_tx && !st.bg_valid) begin
          next_st.sleep = SL_ASLEEP;
        end
      end
      SL_ASLEEP: begin
        if (!sleep_request) begin
          next_st.sleep = SL_SYNC;
        end else if (wakeup_enable && dom_edge) begin
          next_st.sleep = SL_SYNC;
          next_st.wake  = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rx_buffer_full_flag = q_out_valid;
  assign filter_hit_index    = q_out_data[F_HIT_LSB +: 3];
  assign fg_id               = q_out_data[F_ID_LSB +: ID_W];
  assign fg_ide              = q_out_data[F_IDE];
  assign fg_rtr              = q_out_data[F_RTR];
  assign fg_dlc              = q_out_data[F_DLC_LSB +: 4];
  assign fg_data             = q_out_data[F_DATA_LSB +: 64];
  assign rx_irq              = st.rx_irq;
  assign overrun             = st.ovr;
  assign err_irq             = st.err_irq;
  assign can_ack_enable      = ~st.own_tx | loopback;
  // transmissions stay queued while asleep and resynchronising
  assign tx_hold             = (st.sleep == SL_ASLEEP) || (st.sleep == SL_SYNC);
  assign sleep_acknowledge   = (st.sleep == SL_ASLEEP);
  assign wakeup_pulse        = st.wake;
  assign bus_off_recovered   = st.recovered;
  assign bus_synced          = (st.sleep != SL_SYNC) && (st.sleep != SL_ASLEEP);

endmodule

// File: crf_rx_filter_sleep_properties.sv
// port assertions for the receive filter and sleep block
`timescale 1ns/1ps
module crf_rx_filter_sleep_properties import crf_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire logic can_rx,
  input wire logic bit_tick,
  input wire logic tx_start,
  input wire logic arb_lost,
  input wire logic frame_done,
  input wire logic frame_error,
  input wire logic bus_idle,
  input wire logic loopback,
  input wire logic overrun_ie,
  input wire logic sleep_request,
  input wire logic wakeup_enable,
  input wire logic wakeup_pulse,
  input wire logic rx_buffer_full_flag,
  input wire logic rx_irq,
  input wire logic overrun,
  input wire logic err_irq,
  input wire logic can_ack_enable,
  input wire logic tx_hold,
  input wire logic sleep_acknowledge
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ------
  // recessive run while held
  // ------
  // raw pin, so on a recessive run with no dominant cycle this count never runs short of the synchronised one
  logic [3:0] run;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) run <= 4'h0;
    else if (!tx_hold || !can_rx || sleep_acknowledge) run <= 4'h0;
    else if (bit_tick && run != 4'hf) run <= run + 4'h1;
  end
  ovr_irq_a: assert property (overrun && overrun_ie |-> err_irq)
    else $error("overrun without error irq");
  ovr_full_a: assert property (overrun |-> $past(rx_buffer_full_flag))
    else $error("overrun with room in queue");
  push_flag_a: assert property (rx_irq |-> rx_buffer_full_flag)
    else $error("push without full flag");
  bad_drop_a: assert property (frame_done && frame_error && !rx_buffer_full_flag
    && !$past(frame_done) |-> ##2 !rx_irq) else $error("errored frame queued");
  own_noack_a: assert property (tx_start && !arb_lost && !frame_done && !loopback
    |=> !can_ack_enable || loopback) else $error("own frame acknowledged");
  arb_recv_a: assert property (arb_lost |=> can_ack_enable)
    else $error("no receive after lost arbitration");
  wake_clr_a: assert property (sleep_acknowledge && !sleep_request |=> !sleep_acknowledge)
    else $error("request clear did not wake");
  wake_src_a: assert property (wakeup_pulse |-> $past(sleep_acknowledge) && $past(wakeup_enable))
    else $error("bus wake without enable");
  sleep_in_a: assert property ($rose(sleep_acknowledge) |-> $past(bus_idle) && tx_hold)
    else $error("sleep entered on busy bus");
  resync_a: assert property ($fell(tx_hold) |-> run >= REC_RUN_BITS)
    else $error("resync before eleven recessive bits");
endmodule
bind crf_rx_filter_sleep crf_rx_filter_sleep_properties u_props (.*);

// File: crf_can_node.sv
// other nodes on the bus: bit timing, pin level and finished frames
`timescale 1ns/1ps
module crf_can_node import crf_pkg::*; (
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire logic            send,
  input  wire logic            bad,
  input  wire logic            dom,
  input  wire logic [ID_W-1:0] id,
  output logic                 can_rx,
  output logic                 bit_tick,
  output logic                 frame_done,
  output logic                 frame_error,
  output logic [ID_W-1:0]      rx_id,
  output logic [63:0]          rx_data
);
  logic [1:0] div;
  // ------
  // fields churn outside frame_done
  // ------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {div, bit_tick, frame_done, frame_error, rx_id, rx_data} <= '0;
      can_rx <= 1'b1;
    end else begin
      div <= div + 2'h1;
      bit_tick <= div == 2'h3;
      can_rx <= !dom;
      frame_done <= send;
      frame_error <= send ? bad : !frame_error;
      rx_id <= send ? id : ~rx_id;
      rx_data <= send ? {35'h0, id} : ~rx_data;
    end
  end
endmodule

// File: crf_rx_filter_sleep_tb_top.sv
// self-checking bench of the receive filter and sleep block
`timescale 1ns/1ps
module crf_rx_filter_sleep_tb_top import crf_pkg::*; ;
  logic            mclk, rst, send, bad, dom, can_rx, bit_tick, tx_start, arb_lost;
  logic            frame_done, frame_error, rx_ide, rx_rtr, rx_srr, bus_idle, bus_off;
  logic            loopback, overrun_ie, wakeup_enable, sleep_request, fg_release, awake;
  logic            rx_buffer_full_flag, fg_ide, fg_rtr, rx_irq, overrun, err_irq;
  logic            can_ack_enable, tx_hold, sleep_acknowledge, wakeup_pulse;
  logic            bus_off_recovered, bus_synced;
  logic [1:0]      acceptance_control_reg;
  logic [2:0]      filter_hit_index;
  logic [3:0]      rx_dlc, fg_dlc;
  logic [ID_W-1:0] id, rx_id, fg_id, fr;
  logic [63:0]     rx_data, fg_data;
  logic [7:0][7:0] id_accept_pattern_regs, id_mask_regs;
  logic [31:0]     mq[$];
  logic [7:0]      tops[3];
  int              seed, n_errors, comparisons, woke, recs, t;
  crf_can_node node (.*);
  crf_rx_filter_sleep DUT (.*);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // pulses are counted away from the edge that launches them
  always @(negedge mclk) begin
    woke += wakeup_pulse;
    recs += bus_off_recovered;
  end
  // ------
  // checking and model
  // ------
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic stop_test();
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // only the top byte is compared, other mask bytes are all don't care
  function automatic int hit_of(input logic [ID_W-1:0] i);
    for (int k = 0; k < 2; k++)
      if (((id_accept_pattern_regs[4*k] ^ i[28:21]) & ~id_mask_regs[4*k]) == 8'h00) return k;
    return -1;
  endfunction
  task automatic head();
    chk(rx_buffer_full_flag, mq.size() > 0);
    if (mq.size() > 0) chk({filter_hit_index, fg_id, fg_data[28:0]}, {mq[0], mq[0][28:0]});
    if (mq.size() > 0) chk({fg_ide, fg_rtr, fg_dlc}, 6'h28);
  endtask
  task automatic pop();
    fg_release = 1'b1;
    @(negedge mclk);
    fg_release = 1'b0;
    void'(mq.pop_front());
    repeat (3) @(negedge mclk);
    head();
  endtask
  task automatic wait_for(input logic s, input logic v);
    int t;
    t = 0;
    while ((s ? bus_synced : sleep_acknowledge) !== v && t < 300) begin
      @(negedge mclk);
      t++;
    end
    chk(s ? bus_synced : sleep_acknowledge, v);
    if (t == 300) stop_test();
  endtask
  task automatic frame(input logic [ID_W-1:0] i, input logic e, input int own);
    logic irq, ovr, eirq, acc;
    logic [2:0] x;
    int h;
    {irq, ovr, eirq} = 3'h0;
    h = hit_of(i);
    acc = !e && h >= 0 && acceptance_control_reg == ACC_TWO32 && awake && !(own == 1 && !loopback);
    if (own > 0) begin
      tx_start = 1'b1;
      @(negedge mclk);
      tx_start = 1'b0;
      arb_lost = own == 2;
      @(negedge mclk);
      arb_lost = 1'b0;
      chk(can_ack_enable, own == 2 || loopback);
    end
    id = i;
    bad = e;
    send = 1'b1;
    @(negedge mclk);
    send = 1'b0;
    repeat (5) begin
      @(negedge mclk);
      {irq, ovr, eirq} = {irq | rx_irq, ovr | overrun, eirq | err_irq};
    end
    x = {acc && mq.size() < 2, acc && mq.size() == 3, acc && mq.size() == 3 && overrun_ie};
    chk({irq, ovr, eirq}, x);
    if (acc && mq.size() < 3) mq.push_back({3'(h), i});
    head();
  endtask
  // ------
  // main sequence
  // ------
  initial begin
    seed = 32'h6fa5;
    {send, bad, dom, tx_start, arb_lost, loopback, overrun_ie, fg_release} = '0;
    {wakeup_enable, sleep_request, bus_idle, bus_off, rx_rtr, id} = '0;
    {rx_ide, rx_srr, rx_dlc, awake, rst} = {2'h3, 4'h8, 2'h1};
    acceptance_control_reg = ACC_TWO32;
    id_mask_regs = '1;
    id_mask_regs[0] = 8'h01;
    id_accept_pattern_regs = '0;
    id_accept_pattern_regs[0] = 8'h5a;
    tops = '{8'h5a, 8'h5b, 8'h3c};
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    wait_for(1'b1, 1'b1);
    awake = 1'b1;
    for (int n = 0; n < 16; n++) begin
      id_accept_pattern_regs[4] = n[1] ? 8'h5a : 8'h3c;
      fr = 29'($random(seed));
      if (n % 4 != 3) fr[28:21] = tops[n%4];
      frame(fr, n % 5 == 4, 0);
      if (mq.size() > 0) pop();
    end
    for (int n = 0; n < 4; n++) begin
      loopback = n[0];
      frame({8'h5a, 21'(n)}, 1'b0, n < 2 ? 1 : 2);
      if (mq.size() > 0) pop();
    end
    loopback = 1'b0;
    for (int n = 0; n < 5; n++) begin
      overrun_ie = n != 4;
      frame({8'h5a, 21'(n)}, 1'b0, 0);
    end
    repeat (3) pop();
    frame({8'h5a, 21'h7}, 1'b0, 0);
    acceptance_control_reg = ACC_CLOSED;
    frame({8'h5a, 21'h8}, 1'b0, 0);
    acceptance_control_reg = ACC_TWO32;
    bus_idle = 1'b1;
    sleep_request = 1'b1;
    wait_for(1'b0, 1'b1);
    chk(tx_hold, 1'b1);
    awake = 1'b0;
    frame({8'h5a, 21'h9}, 1'b0, 0);
    wakeup_enable = 1'b1;
    dom = 1'b1;
    wait_for(1'b0, 1'b0);
    repeat (8) @(negedge mclk);
    dom = 1'b0;
    repeat (20) @(negedge mclk);
    chk(bus_synced, 1'b0);
    wait_for(1'b1, 1'b1);
    awake = 1'b1;
    head();
    chk(woke, 1);
    {wakeup_enable, sleep_request, bus_idle} = 3'h0;
    bus_off = 1'b1;
    repeat (2000) @(negedge mclk);
    sleep_request = 1'b1;
    repeat (3) @(negedge mclk);
    sleep_request = 1'b0;
    repeat (3) @(negedge mclk);
    chk(sleep_acknowledge, 1'b0);
    chk(bus_synced, 1'b1);
    bus_idle = 1'b1;
    wait_for(1'b1, 1'b1);
    sleep_request = 1'b1;
    wait_for(1'b0, 1'b1);
    sleep_request = 1'b0;
    wait_for(1'b0, 1'b0);
    wait_for(1'b1, 1'b1);
    head();
    chk(woke, 1);
    // a restarted count would need the full 128 runs from here
    for (t = 0; t < 4600 && recs == 0; t++) @(negedge mclk);
    chk(recs, 1);
    stop_test();
  end
endmodule
